// ===== core/gain_bias_pkg.sv
package gain_bias_pkg;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h02;
   localparam logic [6:0] ADDR_A_BIAS = 7'h04;
   localparam logic [6:0] ADDR_A_ATTEN = 7'h05;
   localparam logic [6:0] ADDR_B_BIAS = 7'h06;
   localparam logic [6:0] ADDR_B_ATTEN = 7'h07;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int SRST_A_BIT = 0;
   localparam int SRST_B_BIT = 4;
   localparam logic [7:0] BIAS_RESET = 8'h20;
   localparam logic [5:0] ATTEN_RESET = 6'h0B;
   localparam logic [5:0] ATTEN_MIN = 6'h00;
   localparam logic [5:0] ATTEN_MAX = 6'h27;
   localparam logic [1:0] ATTEN_RSVD = 2'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Power level 0 (lowest) to 8 (highest)
   localparam logic [3:0] LEVEL_LOW = 4'h0;
   localparam logic [3:0] LEVEL_HIGH = 4'h8;

   // One channel's stored control bytes
   typedef struct packed {
      logic [7:0] bias;
      logic [5:0] atten;
   } chan_ctrl_t;

endpackage : gain_bias_pkg

// ===== core/gain_bias_regs.sv
`timescale 1ns/100ps

module gain_bias_regs
   import gain_bias_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [6:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   // Channel control outputs
   output logic [7:0] chan_a_bias_out,
   output logic [7:0] chan_a_atten_out,
   output logic [7:0] chan_b_bias_out,
   output logic [7:0] chan_b_atten_out,
   // Decoded controls
   output logic [3:0] chan_a_level,
   output logic [3:0] chan_b_level,
   output logic [5:0] chan_a_step,
   output logic [5:0] chan_b_step
);

   localparam chan_ctrl_t CHAN_RESET = '{bias: BIAS_RESET, atten: ATTEN_RESET};

   // Power level from the highest set bias bit
   function automatic logic [3:0] bias_level(input logic [7:0] b);
      logic [3:0] lvl;
      lvl = LEVEL_LOW;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
         begin
            lvl = 4'(i + 1);
         end
      end
      return lvl;
   endfunction : bias_level

   // Attenuation step with out-of-range codes clamped
   function automatic logic [5:0] atten_clamp(input logic [5:0] c);
      return (c > ATTEN_MAX) ? ATTEN_MAX : c;
   endfunction : atten_clamp

   chan_ctrl_t a_reg, a_next, b_reg, b_next;
   logic [7:0] rd_reg, rd_next;
   logic [3:0] lva_reg, lva_next, lvb_reg, lvb_next;
   logic [5:0] sta_reg, sta_next, stb_reg, stb_next;
   logic srst_a, srst_b;

   // ------------------------------------------------------------
   // Register write and soft reset
   // ------------------------------------------------------------
   // Soft reset bits act in the write cycle and are never stored
   always_comb
   begin
      srst_a = wr_en && addr == ADDR_SOFT_RESET && wr_data[SRST_A_BIT];
      srst_b = wr_en && addr == ADDR_SOFT_RESET && wr_data[SRST_B_BIT];
      a_next = a_reg;
      b_next = b_reg;
      if (wr_en)
      begin
         unique case (addr)
            ADDR_A_BIAS: a_next.bias = wr_data;
            ADDR_A_ATTEN: a_next.atten = wr_data[5:0];
            ADDR_B_BIAS: b_next.bias = wr_data;
            ADDR_B_ATTEN: b_next.atten = wr_data[5:0];
            default: ;
         endcase
      end
      if (srst_a)
      begin
         a_next = CHAN_RESET;
      end
      if (srst_b)
      begin
         b_next = CHAN_RESET;
      end
   end

   // ------------------------------------------------------------
   // Read data and decode
   // ------------------------------------------------------------
   // Read mux; reserved and unmapped addresses read zero
   always_comb
   begin
      rd_next = rd_reg;
      if (rd_en)
      begin
         unique case (addr)
            ADDR_A_BIAS: rd_next = a_reg.bias;
            ADDR_A_ATTEN: rd_next = {ATTEN_RSVD, a_reg.atten};
            ADDR_B_BIAS: rd_next = b_reg.bias;
            ADDR_B_ATTEN: rd_next = {ATTEN_RSVD, b_reg.atten};
            default: rd_next = READ_ZERO;
         endcase
      end
      lva_next = bias_level(a_next.bias);
      lvb_next = bias_level(b_next.bias);
      sta_next = atten_clamp(a_next.atten);
      stb_next = atten_clamp(b_next.atten);
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         a_reg <= CHAN_RESET;
         b_reg <= CHAN_RESET;
         rd_reg <= READ_ZERO;
         lva_reg <= bias_level(BIAS_RESET);
         lvb_reg <= bias_level(BIAS_RESET);
         sta_reg <= ATTEN_RESET;
         stb_reg <= ATTEN_RESET;
      end
      else
      begin
         a_reg <= a_next;
         b_reg <= b_next;
         rd_reg <= rd_next;
         lva_reg <= lva_next;
         lvb_reg <= lvb_next;
         sta_reg <= sta_next;
         stb_reg <= stb_next;
      end
   end

   // Outputs straight from flip-flops
   assign chan_a_bias_out = a_reg.bias;
   assign chan_b_bias_out = b_reg.bias;
   assign chan_a_atten_out = {ATTEN_RSVD, a_reg.atten};
   assign chan_b_atten_out = {ATTEN_RSVD, b_reg.atten};
   assign rd_data = rd_reg;
   assign chan_a_level = lva_reg;
   assign chan_b_level = lvb_reg;
   assign chan_a_step = sta_reg;
   assign chan_b_step = stb_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_bias_top_high: assert property (@(posedge clk) disable iff (rst)
      chan_a_bias_out[7] |-> chan_a_level == LEVEL_HIGH)
      else $error("top bias bit not highest level");
   chk_bias_zero_low: assert property (@(posedge clk) disable iff (rst)
      chan_b_bias_out == READ_ZERO |-> chan_b_level == LEVEL_LOW)
      else $error("zero bias not lowest level");
   chk_bias_msb_level: assert property (@(posedge clk) disable iff (rst)
      chan_a_bias_out[7:5] == 3'h1 |-> chan_a_level == 4'h6)
      else $error("bias level not from top set bit");
   chk_atten_rsvd_zero: assert property (@(posedge clk)
      chan_a_atten_out[7:6] == ATTEN_RSVD && chan_b_atten_out[7:6] == ATTEN_RSVD)
      else $error("reserved attenuator bits not zero");
   chk_atten_reset_val: assert property (@(posedge clk)
      $past(rst) |-> chan_a_atten_out[5:0] == ATTEN_RESET && chan_b_bias_out == BIAS_RESET)
      else $error("wrong reset values");
   chk_atten_clamp_max: assert property (@(posedge clk) disable iff (rst)
      chan_b_step == ((chan_b_atten_out[5:0] > ATTEN_MAX) ? ATTEN_MAX
      : chan_b_atten_out[5:0]))
      else $error("attenuation step out of range");
   chk_atten_min_pass: assert property (@(posedge clk) disable iff (rst)
      chan_a_atten_out[5:0] == ATTEN_MIN |-> chan_a_step == ATTEN_MIN)
      else $error("minimum attenuation not passed");
   chk_soft_reset_a: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_SOFT_RESET && wr_data[SRST_A_BIT]
      |=> chan_a_bias_out == BIAS_RESET && chan_a_atten_out[5:0] == ATTEN_RESET)
      else $error("soft reset A did not clear channel");
   chk_write_addr_b: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_B_BIAS |=> chan_b_bias_out == $past(wr_data))
      else $error("channel B bias write lost");

   // Channel B soft reset restores both of its bytes
   chk_soft_reset_b: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_SOFT_RESET && wr_data[SRST_B_BIT]
      |=> chan_b_bias_out == BIAS_RESET && chan_b_atten_out[5:0] == ATTEN_RESET)
      else $error("soft reset B did not clear channel");

   // A zero in the channel A reset bit leaves that channel alone
   chk_srst_zero_none: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_SOFT_RESET && !wr_data[SRST_A_BIT]
      |=> $stable(chan_a_bias_out) && $stable(chan_a_atten_out))
      else $error("zero soft reset bit changed channel A");

   // Self-clearing reset bits never read back as set
   chk_read_srst_zero: assert property (@(posedge clk) disable iff (rst)
      rd_en && addr == ADDR_SOFT_RESET |=> rd_data == READ_ZERO)
      else $error("soft reset register read not zero");

   // Channel A writes land at their own addresses
   chk_write_addr_a: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_A_BIAS |=> chan_a_bias_out == $past(wr_data))
      else $error("channel A bias write lost");

   chk_atten_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_A_ATTEN |=> chan_a_atten_out[5:0] == $past(wr_data[5:0]))
      else $error("channel A attenuator write lost");

   chk_atten_write_b: assert property (@(posedge clk) disable iff (rst)
      wr_en && addr == ADDR_B_ATTEN |=> chan_b_atten_out[5:0] == $past(wr_data[5:0]))
      else $error("channel B attenuator write lost");

   // Reserved attenuator bits read back as zero
   chk_read_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      rd_en && addr == ADDR_A_ATTEN |=> rd_data[7:6] == ATTEN_RSVD)
      else $error("reserved attenuator bits read non-zero");

   // Top valid code gives maximum attenuation on channel A
   chk_atten_max_a: assert property (@(posedge clk) disable iff (rst)
      chan_a_atten_out[5:0] == ATTEN_MAX |-> chan_a_step == ATTEN_MAX)
      else $error("maximum attenuation not passed");

   // Channel B level also follows the top set bias bit
   chk_bias_level_b: assert property (@(posedge clk) disable iff (rst)
      chan_b_bias_out[7:5] == 3'h1 |-> chan_b_level == 4'h6)
      else $error("channel B bias level not from top set bit");

endmodule : gain_bias_regs

// ===== tb/dual_channel_gain_bias_decode_tb.sv
`timescale 1ns/100ps
module dual_channel_gain_bias_decode_tb;
   import gain_bias_pkg::*;
   // ----------------------------------------
   // Stimulus, model and checks
   // ----------------------------------------
   logic clk, rst, wr_en, rd_en;
   logic [6:0] addr;
   logic [7:0] wr_data, rd_data, a_b, a_t, b_b, b_t, v;
   logic [3:0] a_l, b_l;
   logic [5:0] a_s, b_s;
   logic [7:0] mb [2];
   logic [5:0] ma [2];
   logic [7:0] ac [6] = '{8'hC0, 8'h27, 8'h68, 8'hFF, 8'h0B, 8'h26};
   int mismatches, cmp_count, cycles;
   gain_bias_regs uut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .chan_a_bias_out(a_b), .chan_a_atten_out(a_t),
      .chan_b_bias_out(b_b), .chan_b_atten_out(b_t), .chan_a_level(a_l),
      .chan_b_level(b_l), .chan_a_step(a_s), .chan_b_step(b_s));
   // Expected power level: one above the top set bit
   function automatic logic [7:0] lvl(input logic [7:0] b);
      lvl = 8'h00;
      for (int i = 0; i < 8; i++)
         if (b[i]) lvl = 8'(i + 1);
   endfunction : lvl
   // Expected step: codes past the top one clamp
   function automatic logic [7:0] stp(input logic [5:0] c);
      stp = {2'h0, (c > ATTEN_MAX) ? ATTEN_MAX : c};
   endfunction : stp
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rs(input int c);
      mb[c] = BIAS_RESET;
      ma[c] = ATTEN_RESET;
   endtask : rs
   task automatic check_all();
      chk("a_bias", mb[0], a_b);
      chk("b_bias", mb[1], b_b);
      chk("a_atten", {2'h0, ma[0]}, a_t);
      chk("b_atten", {2'h0, ma[1]}, b_t);
      chk("a_level", lvl(mb[0]), {4'h0, a_l});
      chk("b_level", lvl(mb[1]), {4'h0, b_l});
      chk("a_step", stp(ma[0]), {2'h0, a_s});
      chk("b_step", stp(ma[1]), {2'h0, b_s});
   endtask : check_all
   // One write strobe, then the model follows
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      if (a == ADDR_A_BIAS) mb[0] = d;
      if (a == ADDR_A_ATTEN) ma[0] = d[5:0];
      if (a == ADDR_B_BIAS) mb[1] = d;
      if (a == ADDR_B_ATTEN) ma[1] = d[5:0];
      if (a == ADDR_SOFT_RESET && d[SRST_A_BIT]) rs(0);
      if (a == ADDR_SOFT_RESET && d[SRST_B_BIT]) rs(1);
   endtask : wr
   // One read strobe, data compared a cycle later
   task automatic rd(input logic [6:0] a);
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      v = (a == ADDR_A_BIAS) ? mb[0] : (a == ADDR_B_BIAS) ? mb[1] : READ_ZERO;
      if (a == ADDR_A_ATTEN) v = {2'h0, ma[0]};
      if (a == ADDR_B_ATTEN) v = {2'h0, ma[1]};
      chk("rd_data", v, rd_data);
   endtask : rd
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   // Clock at 25 ns
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   // Main sequence
   initial
   begin
      {rst, wr_en, rd_en, addr, wr_data} = {1'b1, 17'h0};
      void'($urandom(88150));
      rs(0);
      rs(1);
      repeat (12) @(negedge clk);
      rst = 1'b0;
      check_all();
      $display("test reset done");
      for (int i = 0; i < 9; i++)
      begin
         v = (i == 0) ? 8'h00 : (8'h01 << (i - 1));
         wr(ADDR_A_BIAS, v | (8'($urandom) & (v - 8'h01) & {8{i != 0}}));
         wr(ADDR_B_BIAS, (i == 0) ? 8'h00 : 8'($urandom));
         check_all();
      end
      $display("test bias done");
      for (int i = 0; i < 6; i++)
      begin
         wr(ADDR_A_ATTEN, ac[i]);
         wr(ADDR_B_ATTEN, 8'($urandom));
         rd(ADDR_A_ATTEN);
         check_all();
      end
      wr(ADDR_A_ATTEN, 8'h40);
      check_all();
      $display("test atten done");
      wr(ADDR_SOFT_RESET, 8'hEE);
      check_all();
      wr(ADDR_SOFT_RESET, 8'h01);
      check_all();
      rd(ADDR_SOFT_RESET);
      wr(ADDR_SOFT_RESET, 8'h10);
      check_all();
      $display("test soft reset done");
      for (int i = 0; i < 300; i++)
      begin
         addr = 7'($urandom_range(0, 12));
         if ($urandom_range(0, 1) == 1) wr(addr, 8'($urandom));
         else rd(addr);
         check_all();
      end
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      rs(0);
      rs(1);
      check_all();
      $display("test random done");
      end_of_test();
   end
endmodule : dual_channel_gain_bias_decode_tb
